// file: common/tif_defs.svh
// Purpose: Offsets, field positions, reset values and masks of the timer interrupt flag block.
// Assumes: 32-bit register bus, one aligned word per register.
// Notes: Definitions only.
`ifndef TIF_DEFS_SVH
`define TIF_DEFS_SVH

// ==========================================================================
// Register byte addresses
`define TIF_PEND_ADDR 32'h0000_4614
`define TIF_EN_ADDR 32'h0000_462c
`define TIF_CAPCFG_ADDR 32'h0000_4630
`define TIF_T1_THR_ADDR 32'h0000_4634
`define TIF_T2_THR_ADDR 32'h0000_4638

// ==========================================================================
// Event bit positions within one timer byte
`define TIF_BIT_WRAP 0
`define TIF_BIT_CMPA 1
`define TIF_BIT_CMPB 2
`define TIF_BIT_ZERO 3
`define TIF_BIT_TOP 4
`define TIF_BIT_CAPA 5
`define TIF_BIT_CAPB 6
`define TIF_TIMER_STRIDE 8

// ==========================================================================
// Masks and reset values
`define TIF_IMPL_MASK 16'h7f7f
`define TIF_REG_RESET 16'h0000
`define TIF_CAPCFG_RESET 8'h00
`define TIF_THR_RESET 16'hffff
`define TIF_COUNT_ZERO 16'h0000
`define TIF_RDATA_ZERO 32'h0000_0000

`endif

// file: common/tif_pkg.sv
// Purpose: Types shared by the timer interrupt flag block.
// Assumes: Constants live in tif_defs.svh.
// Notes: Capture edge codes follow the two-bit edge selection field.
package tif_pkg;

    typedef enum logic [1:0] {
        TIF_EDGE_OFF = 2'b00,
        TIF_EDGE_RISE = 2'b01,
        TIF_EDGE_FALL = 2'b10,
        TIF_EDGE_BOTH = 2'b11
    } tif_edge_type;

    // Per timer inputs from the counter, compare and wrap logic.
    typedef struct packed {
        logic [15:0] count;
        logic tick;
        logic wrap;
        logic cmp_a;
        logic cmp_b;
    } tif_timer_in_type;

    // Address phase of a bus transfer held into its data phase.
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [2:0] size;
    } tif_ahb_req_type;

endpackage : tif_pkg

// file: verilog/tif_timer_irq.sv
// Purpose: Pending flags, enables and interrupt request for two 16-bit timers.
// Assumes: AHB-Lite slave, zero wait states, 125 MHz i_ref_clk, async active-low reset.
// Notes: Capture pins are asynchronous and pass a two-stage synchroniser.
//
// Function
// RL1: Capture B enable at bit 14 for timer 2, bit 6 for timer 1.
// RL2: Capture A enable at bit 13 for timer 2, bit 5 for timer 1.
// RL3: Compare-top enable at bit 12 for timer 2, bit 4 for timer 1.
// RL4: Compare-zero enable at bit 11 for timer 2, bit 3 for timer 1.
// RL5: Compare B enable at bit 10 for timer 2, bit 2 for timer 1.
// RL6: Capture B event sets pending bit 14 or 6.
// RL7: Capture A event sets pending bit 13 or 5.
// RL8: Counter matching its threshold sets pending bit 12 or 4.
// RL9: Counter reaching zero sets pending bit 11 or 3.
// RL10: Compare A match sets pending bit 9 or 1.
// RL11: Compare-top match uses each timer's own 16-bit threshold.
// RL12: Capture edge select: 0 off, 1 rising, 2 falling, 3 both.
// RL13: Compare B pending 10/2, compare A enable 9/1, wrap at 8/0.
// RL14: Request asserts while any pending flag has its enable set; bits 15, 7 zero.
//
// Design decision made here: the AHB-Lite register port.
`include "tif_defs.svh"

module tif_timer_irq
    import tif_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // Timer event sources, index 0 is timer 1
    input tif_timer_in_type [1:0] i_timer,
    // Capture pins, index timer*2 + channel, channel 0 is A
    input wire logic [3:0] i_capture_pin,
    // Interrupt request
    output logic o_timer_irq
);

    // ==========================================================================
    // Bus address and data phase
    logic dp_q;
    tif_ahb_req_type req_q;
    logic hready_q;
    logic hresp_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    wire addr_phase = i_hsel & i_hready & i_htrans[1];
    wire rd_phase = addr_phase & ~i_hwrite;
    wire wr_active = dp_q & req_q.write;
    wire wr_pend = wr_active && (req_q.addr == `TIF_PEND_ADDR);
    wire wr_en = wr_active && (req_q.addr == `TIF_EN_ADDR);
    wire wr_capcfg = wr_active && (req_q.addr == `TIF_CAPCFG_ADDR);
    wire wr_thr1 = wr_active && (req_q.addr == `TIF_T1_THR_ADDR);
    wire wr_thr2 = wr_active && (req_q.addr == `TIF_T2_THR_ADDR);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_q <= 1'b0;
            req_q <= '0;
        end else begin
            dp_q <= addr_phase;
            if (addr_phase) begin
                req_q <= '{addr: i_haddr, write: i_hwrite, size: i_hsize};
            end
        end
    end

    // The slave never stretches a transfer and always answers OKAY.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // ==========================================================================
    // Configuration registers
    logic [15:0] en_q;
    logic [15:0] en_d;
    logic [7:0] capcfg_q;
    logic [7:0] capcfg_d;
    logic [1:0][15:0] thr_q;
    logic [1:0][15:0] thr_d;

    assign en_d = wr_en ? (i_hwdata[15:0] & `TIF_IMPL_MASK) : en_q; // RL1 RL2 RL3 RL4 RL5 RL13 RL14
    assign capcfg_d = wr_capcfg ? i_hwdata[7:0] : capcfg_q;
    assign thr_d[0] = wr_thr1 ? i_hwdata[15:0] : thr_q[0];
    assign thr_d[1] = wr_thr2 ? i_hwdata[15:0] : thr_q[1];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= `TIF_REG_RESET;
            capcfg_q <= `TIF_CAPCFG_RESET;
            thr_q <= {`TIF_THR_RESET, `TIF_THR_RESET};
        end else begin
            en_q <= en_d;
            capcfg_q <= capcfg_d;
            thr_q <= thr_d;
        end
    end

    // ==========================================================================
    // Capture pin synchronisers and edge detection
    logic [3:0] cap_meta_q;
    logic [3:0] cap_sync_q;
    logic [3:0] cap_prev_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_meta_q <= 4'h0;
            cap_sync_q <= 4'h0;
            cap_prev_q <= 4'h0;
        end else begin
            cap_meta_q <= i_capture_pin;
            cap_sync_q <= cap_meta_q;
            cap_prev_q <= cap_sync_q;
        end
    end

    wire [3:0] cap_rise = cap_sync_q & ~cap_prev_q;
    wire [3:0] cap_fall = ~cap_sync_q & cap_prev_q;
    logic [3:0] cap_evt;

    // ==========================================================================
    // Event collection per timer
    logic [15:0] ev;

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            localparam int B = t * `TIF_TIMER_STRIDE;
            tif_edge_type sel_a;
            tif_edge_type sel_b;
            assign sel_a = tif_edge_type'(capcfg_q[t * 4 +: 2]);
            assign sel_b = tif_edge_type'(capcfg_q[t * 4 + 2 +: 2]);
            assign cap_evt[t * 2] = ((sel_a == TIF_EDGE_RISE) & cap_rise[t * 2]) // RL12
                | ((sel_a == TIF_EDGE_FALL) & cap_fall[t * 2])
                | ((sel_a == TIF_EDGE_BOTH) & (cap_rise[t * 2] | cap_fall[t * 2]));
            assign cap_evt[t * 2 + 1] = ((sel_b == TIF_EDGE_RISE) & cap_rise[t * 2 + 1]) // RL12
                | ((sel_b == TIF_EDGE_FALL) & cap_fall[t * 2 + 1])
                | ((sel_b == TIF_EDGE_BOTH) & (cap_rise[t * 2 + 1] | cap_fall[t * 2 + 1]));
            assign ev[B + `TIF_BIT_CAPB] = cap_evt[t * 2 + 1]; // RL6
            assign ev[B + `TIF_BIT_CAPA] = cap_evt[t * 2]; // RL7
            // Matching is qualified by the count tick so a stopped counter sets the flag once.
            assign ev[B + `TIF_BIT_TOP] = i_timer[t].tick && (i_timer[t].count == thr_q[t]); // RL8 RL11
            assign ev[B + `TIF_BIT_ZERO] = i_timer[t].tick && (i_timer[t].count == `TIF_COUNT_ZERO); // RL9
            assign ev[B + `TIF_BIT_CMPB] = i_timer[t].cmp_b; // RL13
            assign ev[B + `TIF_BIT_CMPA] = i_timer[t].cmp_a; // RL10
            assign ev[B + `TIF_BIT_WRAP] = i_timer[t].wrap; // RL13
            assign ev[B + 7] = 1'b0; // RL14
        end
    endgenerate

    // ==========================================================================
    // Pending flags and request
    logic [15:0] pend_q;
    logic [15:0] pend_d;
    logic irq_q;

    // Writing one clears a flag; an event in the same cycle wins over the clear.
    wire [15:0] clr_mask = wr_pend ? i_hwdata[15:0] : `TIF_REG_RESET;
    assign pend_d = ((pend_q & ~clr_mask) | ev) & `TIF_IMPL_MASK; // RL6 RL7 RL8 RL9 RL10 RL13 RL14

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= `TIF_REG_RESET;
            irq_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            irq_q <= |(pend_d & en_d); // RL14
        end
    end

    // ==========================================================================
    // Read data, taken from next values so a read right after a write sees it
    assign rdata_d = !rd_phase ? `TIF_RDATA_ZERO
        : (i_haddr == `TIF_PEND_ADDR) ? {16'h0000, pend_d}
        : (i_haddr == `TIF_EN_ADDR) ? {16'h0000, en_d}
        : (i_haddr == `TIF_CAPCFG_ADDR) ? {24'h00_0000, capcfg_d}
        : (i_haddr == `TIF_T1_THR_ADDR) ? {16'h0000, thr_d[0]}
        : (i_haddr == `TIF_T2_THR_ADDR) ? {16'h0000, thr_d[1]}
        : `TIF_RDATA_ZERO;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= `TIF_RDATA_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_hreadyout = hready_q;
    assign o_hresp = hresp_q;
    assign o_hrdata = rdata_q;
    assign o_timer_irq = irq_q;

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    resv_bits_zero_a: assert property ((pend_q & ~`TIF_IMPL_MASK) == 16'h0000 // RL14
        && (en_q & ~`TIF_IMPL_MASK) == 16'h0000)
        else $error("Reserved bit 15 or 7 is set.");

    irq_tracks_flags_a: assert property (o_timer_irq == |(pend_q & en_q)) // RL14
        else $error("Interrupt request disagrees with pending and enable.");

    enable_write_a: assert property (wr_en |=> en_q == ($past(i_hwdata[15:0]) & `TIF_IMPL_MASK)) // RL1
        else $error("Enable register did not take written value.");

    capb_set_a: assert property (cap_evt[3] |=> pend_q[14]) // RL6
        else $error("Timer 2 capture B event did not set its flag.");

    capa_rise_a: assert property ($rose(cap_sync_q[0]) && capcfg_q[1:0] == 2'b01 // RL7
        |=> pend_q[5])
        else $error("Timer 1 rising capture A did not set its flag.");

    capa_off_a: assert property (capcfg_q[5:4] == 2'b00 |-> !cap_evt[2]) // RL12
        else $error("Disabled capture channel produced an event.");

    top_match_a: assert property (i_timer[1].tick && i_timer[1].count == thr_q[1] // RL8
        |=> pend_q[12])
        else $error("Timer 2 threshold match did not set compare-top flag.");

    zero_match_a: assert property (i_timer[0].tick && i_timer[0].count == 16'h0000 // RL9
        |=> pend_q[3])
        else $error("Timer 1 zero count did not set compare-zero flag.");

    cmpa_set_a: assert property (i_timer[0].cmp_a |=> pend_q[1]) // RL10
        else $error("Timer 1 compare A did not set its flag.");

    wrap_hold_a: assert property (pend_q[8] && !wr_pend |=> pend_q[8]) // RL13
        else $error("Timer 2 wrap flag dropped without a clear.");

    clear_works_a: assert property (wr_pend |=> (pend_q & $past(clr_mask & ~ev)) == 16'h0000) // RL14
        else $error("Write of one did not clear a pending flag.");

    read_enable_a: assert property (dp_q && !req_q.write && req_q.addr == `TIF_EN_ADDR // RL1
        |-> o_hrdata == {16'h0000, en_q})
        else $error("Enable register read returned wrong data.");

    // Per field checks, so a slip in one field position cannot hide behind the whole-word check.
    en_capb_bits_a: assert property (wr_en // RL1
        |=> en_q[14] == $past(i_hwdata[14]) && en_q[6] == $past(i_hwdata[6]))
        else $error("Capture B enable bits did not take written value.");

    en_capa_bits_a: assert property (wr_en // RL2
        |=> en_q[13] == $past(i_hwdata[13]) && en_q[5] == $past(i_hwdata[5]))
        else $error("Capture A enable bits did not take written value.");

    en_top_bits_a: assert property (wr_en // RL3
        |=> en_q[12] == $past(i_hwdata[12]) && en_q[4] == $past(i_hwdata[4]))
        else $error("Compare-top enable bits did not take written value.");

    en_zero_bits_a: assert property (wr_en // RL4
        |=> en_q[11] == $past(i_hwdata[11]) && en_q[3] == $past(i_hwdata[3]))
        else $error("Compare-zero enable bits did not take written value.");

    en_cmpb_bits_a: assert property (wr_en // RL5
        |=> en_q[10] == $past(i_hwdata[10]) && en_q[2] == $past(i_hwdata[2]))
        else $error("Compare B enable bits did not take written value.");

    en_cmpa_wrap_a: assert property (wr_en // RL13
        |=> en_q[9:8] == $past(i_hwdata[9:8]) && en_q[1:0] == $past(i_hwdata[1:0]))
        else $error("Compare A or wrap enable bits did not take written value.");

    en_hold_a: assert property (!wr_en // RL5
        |=> $stable(en_q))
        else $error("Enable register changed without a write.");

    capb_one_set_a: assert property (cap_evt[1] // RL6
        |=> pend_q[6])
        else $error("Timer 1 capture B event did not set its flag.");

    capa_one_set_a: assert property (cap_evt[0] // RL7
        |=> pend_q[5])
        else $error("Timer 1 capture A event did not set its flag.");

    top_one_match_a: assert property (i_timer[0].tick && i_timer[0].count == thr_q[0] // RL11
        |=> pend_q[4])
        else $error("Timer 1 threshold match did not set compare-top flag.");

    zero_two_match_a: assert property (i_timer[1].tick && i_timer[1].count == 16'h0000 // RL9
        |=> pend_q[11])
        else $error("Timer 2 zero count did not set compare-zero flag.");

    cmpa_two_set_a: assert property (i_timer[1].cmp_a // RL10
        |=> pend_q[9])
        else $error("Timer 2 compare A did not set its flag.");

    cmpb_two_set_a: assert property (i_timer[1].cmp_b // RL13
        |=> pend_q[10])
        else $error("Timer 2 compare B did not set its flag.");

    wrap_one_set_a: assert property (i_timer[0].wrap // RL13
        |=> pend_q[0])
        else $error("Timer 1 wrap did not set its flag.");

    event_beats_clear_a: assert property (ev != 16'h0000 // RL6
        |=> (pend_q & $past(ev)) == $past(ev))
        else $error("An event was lost to a clearing write.");

    no_stray_set_a: assert property (ev == 16'h0000 // RL14
        |=> (pend_q & ~$past(pend_q)) == 16'h0000)
        else $error("A pending flag was set without an event.");

    fall_select_a: assert property ($fell(cap_sync_q[1]) && capcfg_q[3:2] == 2'b10 // RL12
        |=> pend_q[6])
        else $error("Falling capture edge did not set its flag.");

    rise_ignored_a: assert property (capcfg_q[3:2] == 2'b10 && cap_rise[1] // RL12
        |-> !cap_evt[1])
        else $error("Rising edge counted on a falling-edge channel.");

    both_select_a: assert property (capcfg_q[7:6] == 2'b11 && (cap_rise[3] || cap_fall[3]) // RL12
        |-> cap_evt[3])
        else $error("Both-edge channel missed an edge.");

    bus_okay_a: assert property (o_hreadyout // RL14
        && !o_hresp)
        else $error("Slave stretched a transfer or answered with an error.");

    read_pending_a: assert property (dp_q && !req_q.write && req_q.addr == `TIF_PEND_ADDR // RL14
        |-> o_hrdata == {16'h0000, pend_q})
        else $error("Pending register read returned wrong data.");

    idle_rdata_a: assert property (!(dp_q && !req_q.write) // RL14
        |-> o_hrdata == `TIF_RDATA_ZERO)
        else $error("Read data not zero outside a read data phase.");

    thr_write_a: assert property (wr_thr2 // RL11
        |=> thr_q[1] == $past(i_hwdata[15:0]))
        else $error("Timer 2 threshold did not take written value.");

endmodule : tif_timer_irq

// file: testbench/tif_timer_irq_tb.sv
// Purpose: Self-checking bench for the timer interrupt flag block.
// Assumes: One AHB-Lite master; the bench ties hready to the slave's hreadyout.
// Notes: Capture pins move on clock edges, so a short fixed wait covers synchroniser latency.
`include "tif_defs.svh"

module tif_timer_irq_tb
    import tif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================================
    // Stimulus and observation
    logic clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    tif_timer_in_type [1:0] tmr;
    logic [3:0] pins;
    logic irq;
    int bad_count;
    int tests_run;
    int cycles;

    tif_timer_irq dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_timer(tmr),
        .i_capture_pin(pins), .o_timer_irq(irq)
    );

    always #4 clk = ~clk;

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ==========================================================================
    // Shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic bus_op(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        check("response", 32'h0000_0000, {31'h0, hresp});
    endtask : bus_op

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus_op(1'b1, a, {16'h0000, d}, r);
    endtask : wr

    task automatic rd_chk(input string n, input logic [31:0] a, input logic [15:0] exp);
        logic [31:0] r;
        bus_op(1'b0, a, 32'h0000_0000, r);
        check(n, {16'h0000, exp}, r);
    endtask : rd_chk

    // Strobe kinds: 0 wrap, 1 compare A, 2 compare B, 3 count tick.
    task automatic pulse(input int k, input int which, input logic [15:0] cnt);
        @(posedge clk);
        tmr[k].count <= cnt;
        case (which)
            0: tmr[k].wrap <= 1'b1;
            1: tmr[k].cmp_a <= 1'b1;
            2: tmr[k].cmp_b <= 1'b1;
            default: tmr[k].tick <= 1'b1;
        endcase
        @(posedge clk);
        tmr[k] <= '0;
    endtask : pulse

    // ==========================================================================
    // Scenarios
    task automatic t_regs();
        rd_chk("pending reset", `TIF_PEND_ADDR, 16'h0000);
        rd_chk("enable reset", `TIF_EN_ADDR, 16'h0000);
        rd_chk("threshold reset", `TIF_T2_THR_ADDR, 16'hffff);
        rd_chk("threshold one reset", `TIF_T1_THR_ADDR, 16'hffff);
        rd_chk("capture select reset", `TIF_CAPCFG_ADDR, 16'h0000);
        wr(`TIF_EN_ADDR, 16'hffff);
        rd_chk("enable all", `TIF_EN_ADDR, 16'h7f7f);
        wr(`TIF_EN_ADDR, 16'h2a55);
        rd_chk("enable pattern", `TIF_EN_ADDR, 16'h2a55);
        wr(`TIF_EN_ADDR, 16'h5500);
        rd_chk("enable upper", `TIF_EN_ADDR, 16'h5500);
        wr(`TIF_PEND_ADDR, 16'hffff);
        rd_chk("pending write", `TIF_PEND_ADDR, 16'h0000);
        wr(32'h0000_4618, 16'h1234);
        rd_chk("unmapped", 32'h0000_4618, 16'h0000);
    endtask : t_regs

    task automatic t_events(input int k);
        int b;
        b = k * 8;
        wr(`TIF_PEND_ADDR, 16'hffff);
        wr(`TIF_EN_ADDR, 16'h0002 << b);
        wr(`TIF_T1_THR_ADDR + 4 * k, 16'h00a5);
        pulse(k, 0, 16'h0000);
        @(negedge clk);
        check("irq masked", 32'h0000_0000, {31'h0, irq});
        pulse(k, 1, 16'h0000);
        @(negedge clk);
        check("irq enabled", 32'h0000_0001, {31'h0, irq});
        pulse(k, 2, 16'h0000);
        pulse(k, 3, 16'h00a4);
        pulse(k, 3, 16'h00a5);
        pulse(k, 3, 16'h0000);
        rd_chk("events", `TIF_PEND_ADDR, 16'h001f << b);
        wr(`TIF_PEND_ADDR, 16'h0002 << b);
        @(negedge clk);
        check("irq cleared", 32'h0000_0000, {31'h0, irq});
        rd_chk("after clear", `TIF_PEND_ADDR, 16'h001d << b);
    endtask : t_events

    // Timer 1 A rises, timer 1 B falls, timer 2 A off, timer 2 B both edges.
    task automatic t_capture();
        wr(`TIF_PEND_ADDR, 16'hffff);
        wr(`TIF_CAPCFG_ADDR, 16'h00c9);
        @(posedge clk);
        pins <= 4'hf;
        repeat (6) @(posedge clk);
        rd_chk("capture rise", `TIF_PEND_ADDR, 16'h4020);
        @(posedge clk);
        pins <= 4'h0;
        repeat (6) @(posedge clk);
        rd_chk("capture fall", `TIF_PEND_ADDR, 16'h4060);
        wr(`TIF_EN_ADDR, 16'h4000);
        @(negedge clk);
        check("capture irq", 32'h0000_0001, {31'h0, irq});
    endtask : t_capture

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        tmr = '0;
        pins = 4'h0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_events(0);
        t_events(1);
        t_capture();
        finish_test();
    end

endmodule : tif_timer_irq_tb
